// ---- dv/sepc_core_properties.sv ----
// Concurrent checks on the ports of the serial EEPROM programming block.
// Assumes the host holds every serial level for at least six clocks.
`timescale 1ns/1ps
module sepc_core_properties #(
  parameter int unsigned PROG_CYCLES = sepc_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chipSel,
  input wire logic serClk,
  input wire logic serDataIn,
  input wire logic orgSel,
  input wire logic variantEnh,
  input wire logic serDataOut,
  input wire logic serDataOutEn,
  input wire logic progBusy,
  input wire logic progEnabled
);
  // ****************
  // Busy length counter
  // ****************
  // A second reset clears it, so a cycle cut short is never blamed.
  logic [31:0] busyCnt_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busyCnt_r <= 32'h0;
    end else begin
      busyCnt_r <= progBusy ? busyCnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence busyShown;
    progBusy[*3] ##0 serDataOutEn;
  endsequence
  sequence quietLink;
    (chipSel && !serClk && !progBusy)[*6];
  endsequence
  AST_BUSY_LOW: assert property (busyShown |-> !serDataOut)
    else $error("busy status not shown low");
  AST_READY_HIGH: assert property ($fell(progBusy) && chipSel && $past(chipSel, 6)
    |-> ##[1:2] (serDataOutEn && serDataOut)) else $error("ready not shown high");
  AST_BUSY_DRIVEN: assert property ((chipSel && progBusy)[*6] |-> serDataOutEn)
    else $error("status not driven while selected");
  AST_READY_HOLD: assert property (quietLink ##0 serDataOutEn
    |=> serDataOutEn && $stable(serDataOut)) else $error("status moved on a quiet link");
  AST_START_DESEL: assert property ($rose(progBusy) |-> !$past(chipSel, 2))
    else $error("programming began without deselect");
  AST_ENABLE_GATE: assert property ($rose(progBusy) |-> progEnabled)
    else $error("programming while disabled");
  AST_ENABLE_FRAME: assert property ($changed(progEnabled) |-> chipSel)
    else $error("enable latch moved outside a frame");
  AST_RESET_STATE: assert property ($fell(sys_rst) |-> !progEnabled && !progBusy)
    else $error("reset left programming enabled");
  // Erase, erase-all and write-all run one phase of the cycle; a write runs both.
  AST_BUSY_LEN: assert property ($fell(progBusy) |->
    (busyCnt_r >= PROG_CYCLES / 2 && busyCnt_r <= PROG_CYCLES - PROG_CYCLES / 2 + 6)
    || (busyCnt_r >= PROG_CYCLES - 1 && busyCnt_r <= PROG_CYCLES + 6))
    else $error("programming length wrong");
  AST_BUSY_BOUND: assert property (busyCnt_r <= PROG_CYCLES + 6)
    else $error("programming never ends");
endmodule
bind sepc_core sepc_core_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clock(clock), .sys_rst(sys_rst), .chipSel(chipSel), .serClk(serClk),
  .serDataIn(serDataIn), .orgSel(orgSel), .variantEnh(variantEnh), .serDataOut(serDataOut),
  .serDataOutEn(serDataOutEn), .progBusy(progBusy), .progEnabled(progEnabled));

// ---- dv/sepc_host_model.sv ----
// Host controller model: drives select, serial clock and data in.
// Assumes a synchronised device; every level stands six clocks, clock idles low.
`timescale 1ns/1ps
module sepc_host_model (
  input  wire logic clock,
  input  wire logic serDataOut,
  input  wire logic serDataOutEn,
  output logic      chipSel,
  output logic      serClk,
  output logic      serDataIn
);
  // Data in and out stay separate wires, so the last address bit never fights Q.
  initial {chipSel, serClk, serDataIn} = 3'h0;
  task automatic hold();
    repeat (6) @(posedge clock);
  endtask
  task automatic pulse(input logic d, output logic qs);
    serDataIn <= d;
    hold();
    serClk <= 1'b1;
    hold();
    qs = serDataOut;
    serClk <= 1'b0;
  endtask
  task automatic xfer(input logic [31:0] bits, input int n, input int rd,
                      input logic dummy, output logic [15:0] q);
    logic b;
    q = 16'h0;
    chipSel <= 1'b1;
    hold();
    if (dummy) pulse(1'b0, b);
    for (int i = 31; i > 31 - n; i--) pulse(bits[i], b);
    for (int i = 0; i < rd; i++) begin
      pulse(1'b0, b);
      q = {q[14:0], b};
    end
    hold();
    chipSel   <= 1'b0;
    serDataIn <= 1'b0;
    hold();
  endtask
  task automatic poll(output int cyc, output logic busyShown);
    cyc = 0;
    busyShown = 1'b0;
    chipSel <= 1'b1;
    while (!(serDataOutEn === 1'b1 && serDataOut === 1'b1) && cyc < 1000) begin
      @(posedge clock);
      cyc++;
      if (cyc == 8) busyShown = (serDataOutEn === 1'b1) && (serDataOut === 1'b0);
    end
    chipSel <= 1'b0;
    hold();
  endtask
endmodule

// ---- dv/sepc_tb.sv ----
// Self-checking bench for sepc_core with a host model on the serial pins.
// Assumes a shortened programming cycle of 400 clocks.
`timescale 1ns/1ps
module tb;
  localparam int unsigned PROG = 400;
  localparam int          NR   = 25;
  localparam logic        E    = 1'b1;
  localparam logic        B    = 1'b0;
  localparam logic        W    = 1'b1;
  localparam logic        X8   = 1'b0;
  typedef struct {
    logic enh; logic org; logic [31:0] bits; int n; int rd; logic [15:0] exp;
  } sepc_row_s;
  logic        clock, sys_rst, orgSel, variantEnh, chipSel, serClk, serDataIn;
  logic        serDataOut, serDataOutEn, progBusy, progEnabled, bs;
  logic [15:0] q;
  int          cyc, errors, comparisons;
  int          cycles = 0;
  sepc_row_s   rows [NR];
  function automatic logic [31:0] fw(input logic [3:0] op, input logic [3:0] a,
                                     input logic [15:0] d);
    return {1'b1, op, a, d, 7'h0};
  endfunction
  function automatic logic [31:0] fb(input logic [3:0] op, input logic [4:0] a,
                                     input logic [7:0] d);
    return {1'b1, op, a, d, 14'h0};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always #5 clock = ~clock;
  // A hung wait would never return, so the cycle ceiling closes the run instead.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      give_verdict();
    end
  end
  sepc_core #(.PROG_CYCLES(PROG)) uut (
    .clock(clock), .sys_rst(sys_rst), .chipSel(chipSel), .serClk(serClk),
    .serDataIn(serDataIn), .orgSel(orgSel), .variantEnh(variantEnh),
    .serDataOut(serDataOut), .serDataOutEn(serDataOutEn), .progBusy(progBusy),
    .progEnabled(progEnabled));
  sepc_host_model host (
    .clock(clock), .serDataOut(serDataOut), .serDataOutEn(serDataOutEn),
    .chipSel(chipSel), .serClk(serClk), .serDataIn(serDataIn));
  initial begin
    rows = '{
      '{E, W, fw(4'h4, 4'h3, 16'h1234), 25, 0, 16'h0},
      '{E, W, fw(4'h3, 4'h0, 16'h0), 9, 0, 16'h0},
      '{E, W, fw(4'h4, 4'h3, 16'h1234), 25, 0, 16'h1},
      '{E, W, fw(4'h4, 4'h3, 16'h00F0), 25, 0, 16'h1},
      '{E, W, fw(4'h8, 4'h3, 16'h0), 9, 16, 16'h00F0},
      '{E, W, fw(4'h4, 4'h5, 16'h0), 24, 0, 16'h0},
      '{E, W, fw(4'h4, 4'h5, 16'h0), 26, 0, 16'h0},
      '{E, W, fw(4'h8, 4'h5, 16'h0), 9, 16, 16'hFFFF},
      '{E, W, fw(4'h2, 4'h0, 16'h0), 9, 0, 16'h1},
      '{E, W, fw(4'h8, 4'h3, 16'h0), 9, 16, 16'hFFFF},
      '{E, W, fw(4'h1, 4'h0, 16'hA5C3), 25, 0, 16'h1},
      '{E, W, fw(4'h8, 4'h9, 16'h0), 9, 16, 16'hA5C3},
      '{E, W, fw(4'h1, 4'h0, 16'h0F0F), 25, 0, 16'h1},
      '{E, W, fw(4'h8, 4'h0, 16'h0), 9, 16, 16'h0503},
      '{E, W, fw(4'hC, 4'h0, 16'h0), 9, 0, 16'h1},
      '{E, W, fw(4'hC, 4'h1, 16'h0), 10, 0, 16'h0},
      '{E, X8, fb(4'h4, 5'h07, 8'h3C), 18, 0, 16'h1},
      '{E, X8, fb(4'h4, 5'h07, 8'h11), 17, 0, 16'h0},
      '{E, X8, fb(4'h8, 5'h07, 8'h0), 10, 8, 16'h003C},
      '{E, W, fw(4'h8, 4'h3, 16'h0), 9, 16, 16'h3C03},
      '{B, W, fw(4'h4, 4'h4, 16'hBEEF), 25, 0, 16'h1},
      '{B, W, fw(4'h8, 4'h4, 16'h0), 9, 16, 16'hBEEF},
      '{B, W, fw(4'h0, 4'h0, 16'h0), 9, 0, 16'h0},
      '{B, W, fw(4'h4, 4'h4, 16'h1111), 25, 0, 16'h0},
      '{E, W, fw(4'h8, 4'h4, 16'h0), 9, 16, 16'hBEEF}};
    {clock, sys_rst, orgSel, variantEnh} = 4'h7;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < NR; i++) begin
      @(posedge clock);
      orgSel     <= rows[i].org;
      variantEnh <= rows[i].enh;
      host.xfer(rows[i].bits, rows[i].n, rows[i].rd, !rows[i].enh, q);
      if (rows[i].rd > 0) begin
        check(q, rows[i].exp);
      end else begin
        check(progBusy, rows[i].exp);
        if (progBusy === 1'b1) begin
          host.poll(cyc, bs);
          check(bs, 16'h1);
          check(cyc < 1000, 16'h1);
        end
      end
      $display("test %0d done", i);
    end
    host.xfer(fw(4'h3, 4'h0, 16'h0), 9, 0, 1'b0, q);
    check(progEnabled, 16'h1);
    host.xfer(fw(4'h4, 4'h2, 16'h1111), 25, 0, 1'b0, q);
    host.xfer(fw(4'hC, 4'h2, 16'h0), 9, 0, 1'b0, q);
    host.poll(cyc, bs);
    host.xfer(fw(4'h8, 4'h2, 16'h0), 9, 16, 1'b0, q);
    check(q, 16'h1111);
    $display("test busy ignore done");
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    check({progEnabled, serDataOutEn}, 16'h0);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    host.xfer(fw(4'h8, 4'h2, 16'h0), 9, 16, 1'b0, q);
    check(q, 16'hFFFF);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule

// ---- rtl/sepc_cmd_buf.sv ----
// Two-entry buffer carrying decoded programming commands to the engine.
// Assumes both sides on the same clock; a full buffer holds inReady low.
`timescale 1ns/1ps
module sepc_cmd_buf #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [$clog2(DEPTH+1)-1:0]  used;
    logic [$clog2(DEPTH)-1:0]    rdPtr;
    logic [$clog2(DEPTH)-1:0]    wrPtr;
  } sepc_buf_s;

  sepc_buf_s s_r;
  sepc_buf_s s_nxt;
  logic      push;
  logic      pop;

  assign inReady  = (s_r.used != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign outValid = (s_r.used != '0);
  assign outData  = s_r.slot[s_r.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.slot[s_r.wrPtr] = inData;
      s_nxt.wrPtr = s_r.wrPtr + 1'b1;
    end
    if (pop) begin
      s_nxt.rdPtr = s_r.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.used = s_r.used + 1'b1;
    end else if (pop && !push) begin
      s_nxt.used = s_r.used - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- rtl/sepc_core.sv ----
// Serial EEPROM device logic: frame decoding, self-timed programming,
// ready/busy reporting and the 16 x 16 array itself.
// Assumes the host drives select, serial clock and data asynchronously.
`timescale 1ns/1ps
module sepc_core #(
  parameter int unsigned PROG_CYCLES = sepc_pkg::PROG_CYCLES
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic chipSel,
  input  wire logic serClk,
  input  wire logic serDataIn,
  input  wire logic orgSel,
  input  wire logic variantEnh,
  output logic      serDataOut,
  output logic      serDataOutEn,
  output logic      progBusy,
  output logic      progEnabled
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [31:0] ERASE_CYC = 32'(PROG_CYCLES / 2);
  localparam logic [31:0] WRITE_CYC = 32'(PROG_CYCLES) - ERASE_CYC;

  typedef struct packed {
    logic [4:0]                     syncA;
    logic [4:0]                     syncB;
    logic                           clkOld;
    logic                           selOld;
    sepc_pkg::sepc_frm_e            frm;
    logic [5:0]                     cnt;
    logic [23:0]                    sh;
    logic [1:0]                     op;
    logic [6:0]                     af;
    logic [15:0]                    data;
    logic                           enabled;
    logic                           statusShow;
    logic                           cmdValid;
    sepc_pkg::sepc_cmd_s            cmd;
    logic [15:0]                    rdSh;
    logic [4:0]                     rdLeft;
    logic [4:0]                     rdAddr;
    logic                           rdBit;
    logic                           qBit;
    logic                           qEn;
    sepc_pkg::sepc_eng_e            eng;
    logic [31:0]                    timer;
    sepc_pkg::sepc_cmd_s            job;
    logic [sepc_pkg::MEM_WORDS-1:0][15:0] mem;
  } sepc_core_s;

  sepc_core_s          s_r;
  sepc_core_s          s_nxt;
  sepc_pkg::sepc_cmd_s bufOut;
  logic                bufOutValid;
  logic                bufOutReady;
  logic                cmdReady;
  logic                busy;

  // ****************************************************************
  // Command buffer
  // ****************************************************************
  sepc_cmd_buf #(
    .WIDTH (sepc_pkg::CMD_BITS),
    .DEPTH (2)
  ) u_buf (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .inData   (s_r.cmd),
    .inValid  (s_r.cmdValid),
    .inReady  (cmdReady),
    .outData  (bufOut),
    .outValid (bufOutValid),
    .outReady (bufOutReady)
  );

  assign bufOutReady  = (s_r.eng == sepc_pkg::ENG_IDLE);
  assign busy         = (s_r.eng != sepc_pkg::ENG_IDLE) || bufOutValid || s_r.cmdValid;
  assign serDataOut   = s_r.qBit;
  assign serDataOutEn = s_r.qEn;
  assign progBusy     = busy;
  assign progEnabled  = s_r.enabled;

  function automatic logic [15:0] readWord(input logic [15:0] w, input logic org,
                                           input logic a0);
    readWord = org ? w : {(a0 ? w[15:8] : w[7:0]), 8'h00};
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        rise;
    logic        sel;
    logic        selFall;
    logic        din;
    logic        org;
    logic        enh;
    logic [5:0]  cntN;
    logic [23:0] shN;
    logic [5:0]  hdrLen;
    logic [5:0]  fullLen;
    logic [5:0]  need;
    logic [6:0]  afN;
    logic [1:0]  ext;
    logic [4:0]  addr;
    logic        isProg;
    logic        lenOk;
    logic [3:0]  idx;
    logic [15:0] mask;
    logic [15:0] placed;
    logic [4:0]  dlen;
    logic [4:0]  nextA;
    rise    = 1'b0;
    sel     = 1'b0;
    selFall = 1'b0;
    din     = 1'b0;
    org     = 1'b0;
    enh     = 1'b0;
    cntN    = '0;
    shN     = '0;
    hdrLen  = '0;
    fullLen = '0;
    need    = '0;
    afN     = '0;
    ext     = '0;
    addr    = '0;
    isProg  = 1'b0;
    lenOk   = 1'b0;
    idx     = '0;
    mask    = '0;
    placed  = '0;
    dlen    = '0;
    nextA   = '0;
    s_nxt   = s_r;

    s_nxt.syncA  = {variantEnh, orgSel, serDataIn, serClk, chipSel};
    s_nxt.syncB  = s_r.syncA;
    s_nxt.clkOld = s_r.syncB[sepc_pkg::SY_CLK];
    s_nxt.selOld = s_r.syncB[sepc_pkg::SY_SEL];
    rise    = s_r.syncB[sepc_pkg::SY_CLK] && !s_r.clkOld;
    sel     = s_r.syncB[sepc_pkg::SY_SEL];
    selFall = !sel && s_r.selOld;
    din     = s_r.syncB[sepc_pkg::SY_DIN];
    org     = s_r.syncB[sepc_pkg::SY_ORG];
    enh     = s_r.syncB[sepc_pkg::SY_ENH];
    hdrLen  = org ? sepc_pkg::HDR_LEN_WORD : sepc_pkg::HDR_LEN_BYTE;
    fullLen = org ? sepc_pkg::FRAME_LEN_WORD : sepc_pkg::FRAME_LEN_BYTE;
    dlen    = org ? sepc_pkg::DATA_LEN_WORD : sepc_pkg::DATA_LEN_BYTE;
    ext     = org ? s_r.af[5:4] : s_r.af[6:5];
    addr    = org ? {1'b0, s_r.af[3:0]} : s_r.af[4:0];

    if (s_r.cmdValid && cmdReady) begin
      s_nxt.cmdValid = 1'b0;
    end

    // Programming engine runs on the system clock only, so a stopped or
    // still toggling serial clock has no effect on the cycle.
    idx    = s_r.job.orgWord ? s_r.job.addr[3:0] : s_r.job.addr[4:1];
    mask   = s_r.job.orgWord ? 16'hFFFF : (s_r.job.addr[0] ? 16'hFF00 : 16'h00FF);
    placed = s_r.job.orgWord ? s_r.job.data : {s_r.job.data[7:0], s_r.job.data[7:0]};
    case (s_r.eng)
      sepc_pkg::ENG_IDLE: begin
        if (bufOutValid) begin
          s_nxt.job   = bufOut;
          s_nxt.timer = '0;
          s_nxt.eng   = (bufOut.kind == sepc_pkg::CMD_WRITE_ALL) ?
                        sepc_pkg::ENG_PROG : sepc_pkg::ENG_ERASE;
        end
      end
      sepc_pkg::ENG_ERASE: begin
        s_nxt.timer = s_r.timer + 32'h1;
        if (s_r.timer >= ERASE_CYC - 32'h1) begin
          s_nxt.timer = '0;
          for (int i = 0; i < sepc_pkg::MEM_WORDS; i++) begin
            if (s_r.job.kind == sepc_pkg::CMD_ERASE_ALL) begin
              s_nxt.mem[i] = sepc_pkg::MEM_RESET;
            end else if (i == int'(idx)) begin
              s_nxt.mem[i] = s_r.mem[i] | mask;
            end
          end
          s_nxt.eng = (s_r.job.kind == sepc_pkg::CMD_WRITE) ?
                      sepc_pkg::ENG_PROG : sepc_pkg::ENG_IDLE;
        end
      end
      sepc_pkg::ENG_PROG: begin
        s_nxt.timer = s_r.timer + 32'h1;
        if (s_r.timer >= WRITE_CYC - 32'h1) begin
          s_nxt.timer = '0;
          // Programming only clears bits; without a prior erase-all, write-all
          // ends as the AND of old and new contents in word mode, and in byte mode only in the byte lane that address bit 0 selects.
          for (int i = 0; i < sepc_pkg::MEM_WORDS; i++) begin
            if (s_r.job.kind == sepc_pkg::CMD_WRITE_ALL || i == int'(idx)) begin
              s_nxt.mem[i] = s_r.mem[i] & (placed | ~mask);
            end
          end
          s_nxt.eng = sepc_pkg::ENG_IDLE;
        end
      end
      default: begin
        s_nxt.eng = sepc_pkg::ENG_IDLE;
      end
    endcase

    // Frame decoding.
    case (s_r.frm)
      sepc_pkg::FRM_IDLE: begin
        if (sel) begin
          s_nxt.cnt = '0;
          s_nxt.frm = enh ? sepc_pkg::FRM_START : sepc_pkg::FRM_DUMMY;
        end
      end
      sepc_pkg::FRM_DUMMY: begin
        if (rise && !busy) begin
          s_nxt.frm = sepc_pkg::FRM_START;
        end
      end
      sepc_pkg::FRM_START: begin
        if (rise && !busy && din) begin
          s_nxt.cnt        = 6'h01;
          s_nxt.sh         = 24'h000001;
          s_nxt.statusShow = 1'b0;
          s_nxt.frm        = sepc_pkg::FRM_FRAME;
        end
      end
      sepc_pkg::FRM_FRAME: begin
        if (rise) begin
          shN      = {s_r.sh[22:0], din};
          cntN     = (s_r.cnt == 6'h3F) ? s_r.cnt : s_r.cnt + 6'h01;
          s_nxt.sh = shN;
          s_nxt.cnt = cntN;
          if (cntN == hdrLen) begin
            afN      = org ? {1'b0, shN[5:0]} : shN[6:0];
            s_nxt.op = org ? shN[7:6] : shN[8:7];
            s_nxt.af = afN;
            if ((org ? shN[7:6] : shN[8:7]) == sepc_pkg::OP_READ) begin
              s_nxt.rdAddr = org ? {1'b0, afN[3:0]} : afN[4:0];
              s_nxt.rdSh   = readWord(s_r.mem[org ? afN[3:0] : afN[4:1]], org, afN[0]);
              s_nxt.rdLeft = dlen;
              s_nxt.rdBit  = 1'b0;
              s_nxt.frm    = sepc_pkg::FRM_READ;
            end else if ((org ? shN[7:6] : shN[8:7]) == sepc_pkg::OP_EXT) begin
              if ((org ? afN[5:4] : afN[6:5]) == sepc_pkg::EXT_ENABLE) begin
                s_nxt.enabled = 1'b1;
              end else if ((org ? afN[5:4] : afN[6:5]) == sepc_pkg::EXT_DISABLE) begin
                s_nxt.enabled = 1'b0;
              end
            end
          end
          if (cntN == fullLen) begin
            s_nxt.data = org ? shN[15:0] : {8'h00, shN[7:0]};
          end
        end
      end
      sepc_pkg::FRM_READ: begin
        if (rise) begin
          if (s_r.rdLeft == 5'h00) begin
            nextA        = org ? {1'b0, s_r.rdAddr[3:0] + 4'h1} : s_r.rdAddr + 5'h01;
            s_nxt.rdAddr = nextA;
            s_nxt.rdSh   = readWord(s_r.mem[org ? nextA[3:0] : nextA[4:1]], org, nextA[0]);
            s_nxt.rdBit  = s_nxt.rdSh[15];
            s_nxt.rdSh   = {s_nxt.rdSh[14:0], 1'b0};
            s_nxt.rdLeft = dlen - 5'h01;
          end else begin
            s_nxt.rdBit  = s_r.rdSh[15];
            s_nxt.rdSh   = {s_r.rdSh[14:0], 1'b0};
            s_nxt.rdLeft = s_r.rdLeft - 5'h01;
          end
        end
      end
      default: begin
        s_nxt.frm = sepc_pkg::FRM_IDLE;
      end
    endcase

    // Deselect ends every frame; a complete programming frame launches here.
    if (!sel) begin
      s_nxt.frm = sepc_pkg::FRM_IDLE;
      if (!busy) begin
        s_nxt.statusShow = 1'b0;
      end
      if (selFall && s_r.frm == sepc_pkg::FRM_FRAME && s_r.cnt >= hdrLen) begin
        isProg = 1'b1;
        case (s_r.op)
          sepc_pkg::OP_WRITE: begin
            s_nxt.cmd.kind = sepc_pkg::CMD_WRITE;
            need = fullLen;
          end
          sepc_pkg::OP_ERASE: begin
            s_nxt.cmd.kind = sepc_pkg::CMD_ERASE;
            need = hdrLen;
          end
          sepc_pkg::OP_EXT: begin
            if (ext == sepc_pkg::EXT_ERASE_ALL) begin
              s_nxt.cmd.kind = sepc_pkg::CMD_ERASE_ALL;
              need = hdrLen;
            end else if (ext == sepc_pkg::EXT_WRITE_ALL) begin
              s_nxt.cmd.kind = sepc_pkg::CMD_WRITE_ALL;
              need = fullLen;
            end else begin
              isProg = 1'b0;
            end
          end
          default: begin
            isProg = 1'b0;
          end
        endcase
        // The base variant only needs the frame complete; the enhanced one
        // rejects any extra glitch pulse so a shifted frame cannot land.
        lenOk = enh ? (s_r.cnt == need) : (s_r.cnt >= need);
        if (isProg && lenOk && s_r.enabled) begin
          s_nxt.cmdValid     = 1'b1;
          s_nxt.cmd.orgWord  = org;
          s_nxt.cmd.addr     = addr;
          s_nxt.cmd.data     = s_r.data;
          s_nxt.statusShow   = 1'b1;
        end
      end
    end

    // Output stage: status while a cycle is pending or just finished.
    s_nxt.qEn  = sel && (s_r.statusShow || s_r.frm == sepc_pkg::FRM_READ);
    s_nxt.qBit = (s_r.frm == sepc_pkg::FRM_READ) ? s_r.rdBit : !busy;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_r     <= '0;
      s_r.mem <= {sepc_pkg::MEM_WORDS{sepc_pkg::MEM_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- rtl/sepc_pkg.sv ----
// Shared constants and types of the serial EEPROM programming control block.
// Assumes a single 100 MHz system clock; every serial pin is asynchronous to it.
package sepc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned PROG_TIME_US = 10000;
  localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

  // ****************************************************************
  // Array and frame geometry
  // ****************************************************************
  localparam int unsigned MEM_WORDS      = 16;
  localparam logic [15:0] MEM_RESET      = 16'hFFFF;
  localparam logic [5:0]  HDR_LEN_WORD   = 6'h09;
  localparam logic [5:0]  HDR_LEN_BYTE   = 6'h0A;
  localparam logic [5:0]  FRAME_LEN_WORD = 6'h19;
  localparam logic [5:0]  FRAME_LEN_BYTE = 6'h12;
  localparam logic [4:0]  DATA_LEN_WORD  = 5'h10;
  localparam logic [4:0]  DATA_LEN_BYTE  = 5'h08;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_ERASE      = 2'h3;
  localparam logic [1:0] OP_EXT        = 2'h0;
  localparam logic [1:0] EXT_ENABLE    = 2'h3;
  localparam logic [1:0] EXT_DISABLE   = 2'h0;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;

  // ****************************************************************
  // Synchroniser lanes
  // ****************************************************************
  localparam int unsigned SY_SEL = 0;
  localparam int unsigned SY_CLK = 1;
  localparam int unsigned SY_DIN = 2;
  localparam int unsigned SY_ORG = 3;
  localparam int unsigned SY_ENH = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_WRITE     = 2'h0,
    CMD_ERASE     = 2'h1,
    CMD_ERASE_ALL = 2'h2,
    CMD_WRITE_ALL = 2'h3
  } sepc_cmd_e;

  typedef struct packed {
    sepc_cmd_e   kind;
    logic        orgWord;
    logic [4:0]  addr;
    logic [15:0] data;
  } sepc_cmd_s;

  localparam int unsigned CMD_BITS = $bits(sepc_cmd_s);

  typedef enum logic [2:0] {
    FRM_IDLE  = 3'h0,
    FRM_DUMMY = 3'h1,
    FRM_START = 3'h3,
    FRM_FRAME = 3'h2,
    FRM_READ  = 3'h6
  } sepc_frm_e;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'h0,
    ENG_ERASE = 2'h1,
    ENG_PROG  = 2'h3
  } sepc_eng_e;

endpackage
